//--- psr_consts.svh
`ifndef PSR_CONSTS_SVH
`define PSR_CONSTS_SVH
`define PSR_CLK_MHZ        250
`define PSR_COMM_LOSS_MS   40
`define PSR_COMM_LOSS_CYC  (`PSR_COMM_LOSS_MS * 1000 * `PSR_CLK_MHZ)
`define PSR_BUS_FAIL_S     5
`define PSR_BUS_FAIL_CYC   (`PSR_BUS_FAIL_S * 1000000 * `PSR_CLK_MHZ)
`define PSR_BLINK_MS       250
`define PSR_BLINK_CYC      (`PSR_BLINK_MS * 1000 * `PSR_CLK_MHZ)
`define PSR_ASI_ADDR_ZERO  5'h00
`define PSR_IN_WIDTH       8
`define PSR_OUT_WIDTH      4
`endif

//--- psr_pkg.sv
package psr_pkg;
	typedef enum logic [2:0] {
		PSR_ST_CHECK  = 3'b000,
		PSR_ST_ERASE  = 3'b001,
		PSR_ST_COPY   = 3'b010,
		PSR_ST_NOPROG = 3'b011,
		PSR_ST_STOP   = 3'b100,
		PSR_ST_RUN    = 3'b101
	} psr_state_type;

	typedef enum logic [2:0] {
		PSR_LED_OFF    = 3'b000,
		PSR_LED_GREEN  = 3'b001,
		PSR_LED_RED    = 3'b010,
		PSR_LED_YELLOW = 3'b011,
		PSR_LED_ORANGE = 3'b100
	} psr_color_type;

	typedef struct packed {
		logic [3:0] area;
		logic [3:0] line;
		logic [7:0] device;
	} psr_addr_type;

	typedef struct packed {
		logic int_valid;
		logic card_present;
		logic card_valid;
		logic entry_cut;
		logic saved_run;
	} psr_boot_type;
endpackage

//--- psr_hold_timer.sv
`timescale 1ns/1ps
// flags once cond has held for COUNT consecutive cycles
module psr_hold_timer
#(
	parameter int W     = 32,
	parameter int COUNT = 16
)
(
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic cond,
	output logic      expired_q
);
	logic [W-1:0] cnt_q;

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			cnt_q <= '0;
		else if (!cond)
			cnt_q <= '0;
		else if (cnt_q != W'(COUNT - 1))
			cnt_q <= cnt_q + W'(1);
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			expired_q <= 1'b0;
		else
			expired_q <= cond && (cnt_q == W'(COUNT - 1));
	end
endmodule

//--- psr_core.sv
`timescale 1ns/1ps
`include "psr_consts.svh"
module psr_core
	import psr_pkg::*;
#(
	parameter int IN_W      = `PSR_IN_WIDTH,
	parameter int OUT_W     = `PSR_OUT_WIDTH,
	parameter int LOSS_CYC  = `PSR_COMM_LOSS_CYC,
	parameter int FAIL_CYC  = `PSR_BUS_FAIL_CYC,
	parameter int BLINK_CYC = `PSR_BLINK_CYC
)
(
	input  wire logic          clk,
	input  wire logic          rst,
	input  wire psr_boot_type  boot,
	input  wire logic          has_display,
	input  wire logic          copy_done,
	input  wire logic          erase_done,
	input  wire logic          esc_press,
	input  wire logic          run_req,
	input  wire logic          stop_req,
	input  wire logic          edit_req,
	input  wire logic          param_req,
	input  wire logic          mode_exit,
	input  wire logic          exp_present,
	input  wire logic [IN_W-1:0]  in_pins,
	input  wire logic [OUT_W-1:0] prog_out,
	input  wire logic          left_comm_ok,
	input  wire logic          asi_voltage_ok,
	input  wire logic          asi_comm_ok,
	input  wire logic [4:0]    asi_addr,
	input  wire logic          bus_ok,
	input  wire logic          tool_prog_start,
	input  wire logic          prog_button,
	input  wire logic          addr_write,
	input  wire psr_addr_type  addr_in,
	output psr_state_type      state_q,
	output logic               noprog_prompt_q,
	output logic               copy_start_q,
	output logic               erase_start_q,
	output logic               retain_restore_q,
	output logic               exp_detected_q,
	output logic               eval_en_q,
	output logic [IN_W-1:0]    in_image_q,
	output logic [OUT_W-1:0]   out_drive_q,
	output logic               edit_mode_q,
	output logic               param_mode_q,
	output logic               nv_wr_q,
	output logic               nv_run_q,
	output psr_color_type      base_led_q,
	output psr_color_type      exp_led_q,
	output psr_color_type      sensor_bus_indicator_q,
	output logic               right_link_en_q,
	output psr_color_type      kbus_led_q,
	output logic               kbus_prog_mode_q,
	output psr_addr_type       phys_addr_q
);
	////////////////////////////////////////////////////////////////////////
	psr_state_type state_d;
	logic          prog_avail;
	logic          comm_cut;
	logic          loss_expired;
	logic          bus_fail_expired;
	logic          kbus_armed_q;
	logic          kbus_stored_q;
	logic [31:0]   blink_cnt_q;
	logic          blink_q;

	// an interrupted entry leaves no usable internal program behind
	assign prog_avail = (boot.int_valid && !boot.entry_cut)
		|| (boot.card_present && boot.card_valid);
	assign comm_cut   = !left_comm_ok || !asi_voltage_ok;

	// startup: nothing runs before the check and any copy finish
	always_comb
	begin
		state_d = state_q;
		unique case (state_q)
			PSR_ST_CHECK:
			begin
				if (boot.entry_cut)
					state_d = PSR_ST_ERASE;
				else if (boot.card_present && boot.card_valid)
					state_d = PSR_ST_COPY;
				else if (!boot.int_valid)
					state_d = has_display ? PSR_ST_NOPROG : PSR_ST_STOP;
				else if (boot.saved_run || !has_display)
					state_d = PSR_ST_RUN;
				else
					state_d = PSR_ST_STOP;
			end
			PSR_ST_ERASE:
			begin
				// a half-entered program is gone; only the card can supply one
				if (erase_done)
				begin
					if (boot.card_present && boot.card_valid)
						state_d = PSR_ST_COPY;
					else
						state_d = has_display ? PSR_ST_NOPROG : PSR_ST_STOP;
				end
			end
			PSR_ST_COPY:
			begin
				if (copy_done)
					state_d = (boot.saved_run || !has_display) ? PSR_ST_RUN
						: PSR_ST_STOP;
			end
			PSR_ST_NOPROG:
			begin
				if (esc_press)
					state_d = PSR_ST_STOP;
			end
			PSR_ST_STOP:
			begin
				if (run_req && !edit_mode_q && prog_avail)
					state_d = PSR_ST_RUN;
			end
			PSR_ST_RUN:
			begin
				if (stop_req && !param_mode_q)
					state_d = PSR_ST_STOP;
			end
			default:
				state_d = PSR_ST_CHECK;
		endcase
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			state_q <= PSR_ST_CHECK;
		else
			state_q <= state_d;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			copy_start_q     <= 1'b0;
			erase_start_q    <= 1'b0;
			retain_restore_q <= 1'b0;
			noprog_prompt_q  <= 1'b0;
		end
		else
		begin
			copy_start_q     <= (state_d == PSR_ST_COPY) && (state_q != PSR_ST_COPY);
			erase_start_q    <= (state_d == PSR_ST_ERASE) && (state_q != PSR_ST_ERASE);
			// retained values come back once, as the unit leaves check or copy for stop or run
			retain_restore_q <= (state_q inside {PSR_ST_CHECK, PSR_ST_COPY})
				&& (state_d inside {PSR_ST_STOP, PSR_ST_RUN});
			noprog_prompt_q  <= (state_d == PSR_ST_NOPROG);
		end
	end

	// modules powered later than the base are never seen
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			exp_detected_q <= 1'b0;
		else if (state_q == PSR_ST_CHECK)
			exp_detected_q <= exp_present;
	end

	////////////////////////////////////////////////////////////////////////
	// RUN/STOP datapath
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			in_image_q <= '0;
		else if (state_q == PSR_ST_RUN)
			in_image_q <= in_pins;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			eval_en_q <= 1'b0;
		else
			eval_en_q <= (state_d == PSR_ST_RUN);
	end

	psr_hold_timer
	#(
		.W     (32),
		.COUNT (LOSS_CYC)
	)
	u_loss_timer
	(
		.clk       (clk),
		.rst       (rst),
		.cond      (comm_cut),
		.expired_q (loss_expired)
	);

	// outputs ride through short dropouts, cut after the loss window
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			out_drive_q <= '0;
		else if (state_d != PSR_ST_RUN || loss_expired)
			out_drive_q <= '0;
		else
			out_drive_q <= prog_out;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			nv_wr_q  <= 1'b0;
			nv_run_q <= 1'b0;
		end
		else
		begin
			nv_wr_q  <= (state_q inside {PSR_ST_STOP, PSR_ST_RUN})
				&& (state_d inside {PSR_ST_STOP, PSR_ST_RUN})
				&& (state_d != state_q);
			nv_run_q <= (state_d == PSR_ST_RUN);
		end
	end

	// editing only while stopped, parameter work only while running
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			edit_mode_q <= 1'b0;
		// a request that leaves STOP in this cycle must not open editing
		else if (!has_display || state_q != PSR_ST_STOP || state_d != PSR_ST_STOP
			|| mode_exit)
			edit_mode_q <= 1'b0;
		else if (edit_req)
			edit_mode_q <= 1'b1;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			param_mode_q <= 1'b0;
		else if (!has_display || state_q != PSR_ST_RUN || state_d != PSR_ST_RUN
			|| mode_exit)
			param_mode_q <= 1'b0;
		else if (param_req)
			param_mode_q <= 1'b1;
	end

	////////////////////////////////////////////////////////////////////////
	// indicators
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			base_led_q <= PSR_LED_RED;
		else
			base_led_q <= (state_d == PSR_ST_RUN) ? PSR_LED_GREEN : PSR_LED_RED;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			exp_led_q <= PSR_LED_ORANGE;
		else if (state_d inside {PSR_ST_CHECK, PSR_ST_ERASE, PSR_ST_COPY})
			exp_led_q <= PSR_LED_ORANGE;
		else
			exp_led_q <= left_comm_ok ? PSR_LED_GREEN : PSR_LED_RED;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			blink_cnt_q <= '0;
			blink_q     <= 1'b0;
		end
		else if (blink_cnt_q == 32'(BLINK_CYC - 1))
		begin
			blink_cnt_q <= '0;
			blink_q     <= !blink_q;
		end
		else
			blink_cnt_q <= blink_cnt_q + 32'h00000001;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			sensor_bus_indicator_q <= PSR_LED_RED;
		else if (asi_addr == `PSR_ASI_ADDR_ZERO)
			sensor_bus_indicator_q <= blink_q ? PSR_LED_YELLOW : PSR_LED_RED;
		else
			sensor_bus_indicator_q <= (asi_comm_ok && asi_voltage_ok) ? PSR_LED_GREEN
				: PSR_LED_RED;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			right_link_en_q <= 1'b0;
		else
			right_link_en_q <= asi_voltage_ok;
	end

	////////////////////////////////////////////////////////////////////////
	// building bus commissioning; tool drives one module at a time
	psr_hold_timer
	#(
		.W     (32),
		.COUNT (FAIL_CYC)
	)
	u_fail_timer
	(
		.clk       (clk),
		.rst       (rst),
		.cond      (!bus_ok),
		.expired_q (bus_fail_expired)
	);

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			kbus_armed_q <= 1'b0;
		else if (tool_prog_start)
			kbus_armed_q <= 1'b1;
		else if (kbus_prog_mode_q)
			kbus_armed_q <= 1'b0;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			kbus_prog_mode_q <= 1'b0;
		else if (kbus_prog_mode_q && addr_write)
			kbus_prog_mode_q <= 1'b0;
		else if (kbus_armed_q && prog_button && bus_ok)
			kbus_prog_mode_q <= 1'b1;
	end

	// dark after storing until the bus state next changes mode
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			phys_addr_q   <= '0;
			kbus_stored_q <= 1'b0;
		end
		else if (kbus_prog_mode_q && addr_write)
		begin
			phys_addr_q   <= addr_in;
			kbus_stored_q <= 1'b1;
		end
		else if (tool_prog_start || !bus_ok)
			kbus_stored_q <= 1'b0;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			kbus_led_q <= PSR_LED_OFF;
		else if (bus_fail_expired)
			kbus_led_q <= PSR_LED_RED;
		else if (kbus_prog_mode_q && !addr_write)
			kbus_led_q <= PSR_LED_ORANGE;
		else if (kbus_stored_q || (kbus_prog_mode_q && addr_write))
			kbus_led_q <= PSR_LED_OFF;
		else if (bus_ok)
			kbus_led_q <= PSR_LED_GREEN;
	end

	////////////////////////////////////////////////////////////////////////
	property p_stop_outputs_off;
		@(posedge clk) disable iff (rst)
		(state_q != PSR_ST_RUN) |-> (out_drive_q == '0);
	endproperty
	a_stop_outputs_off: assert property (p_stop_outputs_off)
		else $error("outputs driven outside run");

	property p_stop_no_sample;
		@(posedge clk) disable iff (rst)
		(state_q != PSR_ST_RUN) ##1 (state_q != PSR_ST_RUN) |-> $stable(in_image_q);
	endproperty
	a_stop_no_sample: assert property (p_stop_no_sample)
		else $error("inputs sampled while stopped");

	property p_run_samples;
		@(posedge clk) disable iff (rst)
		(state_q == PSR_ST_RUN) |=> (in_image_q == $past(in_pins));
	endproperty
	a_run_samples: assert property (p_run_samples)
		else $error("input image not refreshed in run");

	property p_copy_before_run;
		@(posedge clk) disable iff (rst)
		(state_q == PSR_ST_COPY) && !copy_done |=> (state_q == PSR_ST_COPY) && !eval_en_q;
	endproperty
	a_copy_before_run: assert property (p_copy_before_run)
		else $error("left copy before it finished");

	property p_nv_on_change;
		@(posedge clk) disable iff (rst)
		(state_q == PSR_ST_STOP) ##1 (state_q == PSR_ST_RUN) |-> nv_wr_q && nv_run_q;
	endproperty
	a_nv_on_change: assert property (p_nv_on_change)
		else $error("state change not saved");

	property p_edit_only_stop;
		@(posedge clk) disable iff (rst)
		edit_mode_q |-> (state_q == PSR_ST_STOP);
	endproperty
	a_edit_only_stop: assert property (p_edit_only_stop)
		else $error("editing outside stop");

	property p_param_only_run;
		@(posedge clk) disable iff (rst)
		param_mode_q |-> (state_q == PSR_ST_RUN);
	endproperty
	a_param_only_run: assert property (p_param_only_run)
		else $error("parameter mode outside run");

	property p_loss_cuts;
		@(posedge clk) disable iff (rst)
		loss_expired |=> (out_drive_q == '0);
	endproperty
	a_loss_cuts: assert property (p_loss_cuts)
		else $error("outputs held after communication loss");

	property p_asi_zero_blink;
		@(posedge clk) disable iff (rst)
		(asi_addr == `PSR_ASI_ADDR_ZERO) |=>
			sensor_bus_indicator_q inside {PSR_LED_RED, PSR_LED_YELLOW};
	endproperty
	a_asi_zero_blink: assert property (p_asi_zero_blink)
		else $error("address zero not flagged");

	property p_store_dark;
		@(posedge clk) disable iff (rst)
		kbus_prog_mode_q && addr_write && !bus_fail_expired |=>
			(kbus_led_q == PSR_LED_OFF) && (phys_addr_q == $past(addr_in));
	endproperty
	a_store_dark: assert property (p_store_dark)
		else $error("address store not shown");

	property p_right_link;
		@(posedge clk) disable iff (rst)
		!asi_voltage_ok |=> !right_link_en_q;
	endproperty
	a_right_link: assert property (p_right_link)
		else $error("right link kept without bus voltage");

	c_boot_run: cover property (@(posedge clk) disable iff (rst)
		(state_q == PSR_ST_CHECK) ##1 (state_q == PSR_ST_RUN));
	c_copy_path: cover property (@(posedge clk) disable iff (rst)
		(state_q == PSR_ST_COPY) ##[1:20] (state_q == PSR_ST_STOP));
	c_noprog: cover property (@(posedge clk) disable iff (rst)
		noprog_prompt_q ##[1:20] (state_q == PSR_ST_STOP));
	c_commission: cover property (@(posedge clk) disable iff (rst)
		kbus_prog_mode_q ##1 !kbus_prog_mode_q);
endmodule

//--- psr_far_model.sv
`timescale 1ns/1ps
// expansion, sensor bus and building bus modules plus the program card
module psr_far_model
#(
	parameter int DLY = 3
)
(
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic copy_start,
	input  wire logic erase_start,
	input  wire logic link_up,
	input  wire logic asi_pwr,
	input  wire logic asi_link,
	input  wire logic kbus_up,
	input  wire logic exp_pwr,
	output logic      copy_done,
	output logic      erase_done,
	output logic      exp_present,
	output logic      left_comm_ok,
	output logic      asi_voltage_ok,
	output logic      asi_comm_ok,
	output logic      bus_ok
);
	int cc;
	int ec;

	// expansion supply; raising it after startup must leave it unseen
	assign exp_present = exp_pwr;
	assign left_comm_ok = link_up;
	assign asi_voltage_ok = asi_pwr;
	// no bus voltage means no slave traffic either
	assign asi_comm_ok = asi_link & asi_pwr;
	assign bus_ok = kbus_up;

	////////////////////////////////////////////////////////////////
	// card copy and erase take a few cycles, never instant
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			cc <= 0;
			ec <= 0;
			copy_done <= 1'b0;
			erase_done <= 1'b0;
		end
		else
		begin
			cc <= copy_start ? DLY : (cc > 0 ? cc - 1 : 0);
			ec <= erase_start ? DLY : (ec > 0 ? ec - 1 : 0);
			copy_done <= (cc == 1);
			erase_done <= (ec == 1);
		end
	end
endmodule

//--- psr_core_tb_top.sv
`timescale 1ns/1ps
`define CHK(nm, e, s) \
	begin \
		cmp_count++; \
		if ((s) !== (e)) \
		begin \
			miscompares++; \
			$display("[ERR] %s exp %0h got %0h", nm, e, s); \
		end \
	end
module psr_core_tb_top
	import psr_pkg::*;
;
	logic          clk;
	logic          rst = 1'b1;
	psr_boot_type  boot = '0;
	psr_addr_type  addr_in = '0;
	psr_addr_type  phys_addr_q;
	psr_state_type state_q;
	psr_color_type base_led_q, exp_led_q, sensor_bus_indicator_q, kbus_led_q;
	logic [7:0]    in_pins = '0, in_image_q;
	logic [3:0]    prog_out = '0, out_drive_q;
	logic [4:0]    asi_addr = 5'h07;
	logic          has_display = 1'b1, esc_press = 1'b0, run_req = 1'b0, stop_req = 1'b0;
	logic          edit_req = 1'b0, param_req = 1'b0, mode_exit = 1'b0;
	logic          tool_prog_start = 1'b0;
	logic          prog_button = 1'b0, addr_write = 1'b0, exp_pwr = 1'b1;
	logic          link_up = 1'b1, asi_pwr = 1'b1, asi_link = 1'b1, kbus_up = 1'b1;
	logic          copy_done, erase_done, exp_present, left_comm_ok;
	logic          asi_voltage_ok, asi_comm_ok, bus_ok;
	logic          noprog_prompt_q, copy_start_q, erase_start_q, retain_restore_q;
	logic          exp_detected_q, eval_en_q, edit_mode_q, param_mode_q, nv_wr_q;
	logic          nv_run_q, right_link_en_q, kbus_prog_mode_q;
	int            miscompares = 0, cmp_count = 0, cyc = 0;

	// long counts shortened so the whole run stays a few hundred cycles
	psr_core #(.LOSS_CYC(20), .FAIL_CYC(50), .BLINK_CYC(4)) dut_u (
		.clk, .rst, .boot, .has_display, .copy_done, .erase_done, .esc_press,
		.run_req, .stop_req, .edit_req, .param_req, .mode_exit, .exp_present,
		.in_pins, .prog_out, .left_comm_ok, .asi_voltage_ok, .asi_comm_ok,
		.asi_addr, .bus_ok, .tool_prog_start, .prog_button, .addr_write, .addr_in,
		.state_q, .noprog_prompt_q, .copy_start_q, .erase_start_q,
		.retain_restore_q, .exp_detected_q, .eval_en_q, .in_image_q, .out_drive_q,
		.edit_mode_q, .param_mode_q, .nv_wr_q, .nv_run_q, .base_led_q, .exp_led_q,
		.sensor_bus_indicator_q, .right_link_en_q, .kbus_led_q, .kbus_prog_mode_q,
		.phys_addr_q);
	psr_far_model far_u (
		.clk, .rst, .copy_start(copy_start_q), .erase_start(erase_start_q),
		.link_up, .asi_pwr, .asi_link, .kbus_up, .exp_pwr, .copy_done, .erase_done,
		.exp_present, .left_comm_ok, .asi_voltage_ok, .asi_comm_ok, .bus_ok);

	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	////////////////////////////////////////////////////////////////
	task automatic tick(input int n = 1);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic pulse(ref logic s);
		s = 1'b1;
		tick();
		s = 1'b0;
	endtask

	task automatic boot_up(input logic [4:0] b, input logic d);
		rst = 1'b1;
		boot = psr_boot_type'(b);
		has_display = d;
		tick(5);
		rst = 1'b0;
	endtask

	task automatic wait_st(input psr_state_type s);
		for (int i = 0; i < 40 && state_q !== s; i++) tick();
		`CHK("state", s, state_q)
	endtask

	task automatic end_of_test();
		$display("compares %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////
	task automatic t_card_boot();
		boot_up(5'b11101, 1'b1);
		tick();
		`CHK("state", PSR_ST_COPY, state_q)
		`CHK("copy_go", 1'b1, copy_start_q)
		`CHK("exp_led", PSR_LED_ORANGE, exp_led_q)
		`CHK("out", 4'h0, out_drive_q)
		wait_st(PSR_ST_RUN);
		`CHK("retain", 1'b1, retain_restore_q)
		`CHK("nv_wr", 1'b0, nv_wr_q)
		`CHK("exp_det", 1'b1, exp_detected_q)
		tick();
		`CHK("exp_led", PSR_LED_GREEN, exp_led_q)
		link_up = 1'b0;
		tick(2);
		`CHK("exp_led", PSR_LED_RED, exp_led_q)
		link_up = 1'b1;
		tick(2);
	endtask

	task automatic t_run_stop();
		in_pins = 8'hA5;
		prog_out = 4'h9;
		tick(2);
		`CHK("in_img", 8'hA5, in_image_q)
		`CHK("out", 4'h9, out_drive_q)
		pulse(stop_req);
		`CHK("state", PSR_ST_STOP, state_q)
		`CHK("out", 4'h0, out_drive_q)
		`CHK("eval", 1'b0, eval_en_q)
		`CHK("nv_wr", 1'b1, nv_wr_q)
		`CHK("nv_run", 1'b0, nv_run_q)
		in_pins = 8'h3C;
		tick(2);
		`CHK("in_img", 8'hA5, in_image_q)
		pulse(param_req);
		tick();
		`CHK("param", 1'b0, param_mode_q)
		pulse(edit_req);
		tick();
		`CHK("edit", 1'b1, edit_mode_q)
		pulse(run_req);
		tick();
		`CHK("state", PSR_ST_STOP, state_q)
		pulse(mode_exit);
		tick();
		pulse(run_req);
		`CHK("state", PSR_ST_RUN, state_q)
		`CHK("nv_wr", 1'b1, nv_wr_q)
		`CHK("nv_run", 1'b1, nv_run_q)
		pulse(edit_req);
		tick();
		`CHK("edit", 1'b0, edit_mode_q)
		pulse(param_req);
		tick();
		`CHK("param", 1'b1, param_mode_q)
		pulse(stop_req);
		tick();
		`CHK("state", PSR_ST_RUN, state_q)
		pulse(mode_exit);
		tick();
	endtask

	task automatic t_loss();
		prog_out = 4'hF;
		tick(2);
		link_up = 1'b0;
		tick(10);
		`CHK("out", 4'hF, out_drive_q)
		tick(15);
		`CHK("out", 4'h0, out_drive_q)
		link_up = 1'b1;
		tick(3);
		`CHK("out", 4'hF, out_drive_q)
		asi_pwr = 1'b0;
		tick(2);
		`CHK("right", 1'b0, right_link_en_q)
		tick(25);
		`CHK("out", 4'h0, out_drive_q)
		asi_pwr = 1'b1;
		tick(3);
		`CHK("right", 1'b1, right_link_en_q)
	endtask

	task automatic t_sensor();
		int nr;
		int ny;
		nr = 0;
		ny = 0;
		asi_addr = 5'h00;
		for (int i = 0; i < 16; i++)
		begin
			tick();
			if (sensor_bus_indicator_q === PSR_LED_RED) nr++;
			if (sensor_bus_indicator_q === PSR_LED_YELLOW) ny++;
		end
		`CHK("blink", 1'b1, (nr > 0 && ny > 0))
		asi_addr = 5'h07;
		tick(2);
		`CHK("asi", PSR_LED_GREEN, sensor_bus_indicator_q)
		asi_link = 1'b0;
		tick(2);
		`CHK("asi", PSR_LED_RED, sensor_bus_indicator_q)
		asi_link = 1'b1;
	endtask

	task automatic t_kbus();
		pulse(prog_button);
		tick(2);
		`CHK("prog", 1'b0, kbus_prog_mode_q)
		pulse(tool_prog_start);
		pulse(prog_button);
		`CHK("prog", 1'b1, kbus_prog_mode_q)
		tick();
		`CHK("kled", PSR_LED_ORANGE, kbus_led_q)
		addr_in.area = 4'h1;
		addr_in.line = 4'h2;
		addr_in.device = 8'h03;
		pulse(addr_write);
		`CHK("addr", 16'h1203, phys_addr_q)
		`CHK("prog", 1'b0, kbus_prog_mode_q)
		`CHK("kled", PSR_LED_OFF, kbus_led_q)
		kbus_up = 1'b0;
		tick(40);
		`CHK("kled", PSR_LED_OFF, kbus_led_q)
		tick(20);
		`CHK("kled", PSR_LED_RED, kbus_led_q)
		kbus_up = 1'b1;
		tick(3);
		`CHK("kled", PSR_LED_GREEN, kbus_led_q)
	endtask

	task automatic t_boots();
		boot_up(5'b00000, 1'b1);
		wait_st(PSR_ST_NOPROG);
		`CHK("prompt", 1'b1, noprog_prompt_q)
		pulse(esc_press);
		tick();
		`CHK("prompt", 1'b0, noprog_prompt_q)
		boot_up(5'b00000, 1'b0);
		wait_st(PSR_ST_STOP);
		`CHK("led", PSR_LED_RED, base_led_q)
		`CHK("prompt", 1'b0, noprog_prompt_q)
		boot_up(5'b10010, 1'b1);
		tick();
		`CHK("state", PSR_ST_ERASE, state_q)
		`CHK("erase", 1'b1, erase_start_q)
		wait_st(PSR_ST_NOPROG);
		pulse(esc_press);
		pulse(run_req);
		tick();
		`CHK("state", PSR_ST_STOP, state_q)
		boot_up(5'b10000, 1'b0);
		wait_st(PSR_ST_RUN);
		`CHK("led", PSR_LED_GREEN, base_led_q)
		exp_pwr = 1'b0;
		boot_up(5'b10000, 1'b1);
		wait_st(PSR_ST_STOP);
		`CHK("out", 4'h0, out_drive_q)
		exp_pwr = 1'b1;
		tick(2);
		`CHK("exp_det", 1'b0, exp_detected_q)
	endtask

	////////////////////////////////////////////////////////////////
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			miscompares++;
			end_of_test();
		end
	end

	initial
	begin
		t_card_boot();
		t_run_stop();
		t_loss();
		t_sensor();
		t_kbus();
		t_boots();
		end_of_test();
	end
endmodule
